// File: design/pltc_top.sv
`timescale 1ns/10ps
// Powerline transceiver control register bank with APB slave
module pltc_top
	import pltc_pkg::*;
(
	input  wire logic        pclk,          // System clock
	input  wire logic        presetn,       // Asynchronous reset, active low
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB enable
	input  wire logic        pwrite,        // APB direction
	input  wire logic [31:0] paddr,         // APB address
	input  wire logic [31:0] pwdata,        // APB write data
	output logic [31:0]      prdata,        // APB read data
	output logic             pready,        // APB ready
	output logic             pslverr,       // APB error
	input  wire logic        cmp0_above,    // Comparator 0 positive above negative
	input  wire logic        cmp1_above,    // Comparator 1 positive above negative
	input  wire logic        opamp_status,  // Op-amp output status
	output pltc_analog_s     analog,        // Analog control word
	output logic [2:0]       dac_oe_n,      // DAC output enables, low drives
	output logic             cmp_out        // Selected debounced comparator
);

	pltc_regs_s r;      // Registered state
	pltc_regs_s next_r; // Next state
	logic       acc;    // Access phase
	logic       wr;     // Write strobe
	logic       hit;    // Mapped address
	logic [1:0] raw;    // Comparator output bits after polarity
	logic [1:0] filt;   // Debounced comparator bits
	logic [1:0] pol;    // Polarities

	// Address decode
	function automatic logic mapped(input logic [31:0] a);
		mapped = (a[31:6] == 26'h0) && (a[1:0] == 2'h0) && (a[5:0] <= OFS_OPA_TRIM);
	endfunction : mapped

	// ================================================================
	// Bus handshake, zero wait states
	assign acc     = psel && penable;
	assign hit     = mapped(paddr);
	assign wr      = acc && pwrite && hit;
	assign pready  = 1'b1;
	assign pslverr = acc && !hit;
	assign prdata  = r.prdata;

	// ================================================================
	// Comparator result: forced low when disabled, then polarity
	assign pol = {r.shared_cfg[BIT_POL1], r.shared_cfg[BIT_POL0]};
	assign raw[0] = (cmp0_above && r.ctl0[BIT_CMP_EN]) ^ pol[0];
	assign raw[1] = (cmp1_above && r.ctl1[BIT_CMP_EN]) ^ pol[1];

	// One filter per comparator
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_deb
			pltc_debounce u_deb (
				.pclk     (pclk),
				.presetn  (presetn),
				.sel      (g == 0 ? r.ctl0[BIT_DEB_LO+1:BIT_DEB_LO] : r.ctl1[BIT_DEB_LO+1:BIT_DEB_LO]),
				.sample   (raw[g]),
				.filtered (filt[g])
			);
		end
	endgenerate

	// Output select
	assign cmp_out = r.shared_cfg[BIT_OUT_SEL] ? filt[1] : filt[0];

	// ================================================================
	// Analog control word
	always_comb begin
		analog.rx_switch_select    = r.sw[BIT_RX_SEL];
		analog.sense_switch_select = r.sw[BIT_SENSE_SEL];
		analog.tx_pin_select       = r.sw[BIT_TX_SEL];
		analog.dac_enable          = r.dac_en[2:0];
		analog.dac0_code           = r.code0[DAC_W-1:0];
		analog.dac1_code           = r.code1[DAC_W-1:0];
		analog.dac2_code           = r.code2[DAC_W-1:0];
		analog.cmp_enable          = {r.ctl1[BIT_CMP_EN], r.ctl0[BIT_CMP_EN]};
		analog.cmp_current         = {r.ctl1[1:0], r.ctl0[1:0]};
		analog.cmp_trim            = {r.trim1[6:0], r.trim0[6:0]};
		analog.cmp_hysteresis      = r.shared_cfg[3:0];
		analog.opamp_enable        = r.opa_ctl[6];
		analog.opamp_bandwidth     = r.opa_ctl[0];
		analog.opamp_trim          = r.opa_trim;
	end
	assign dac_oe_n = ~r.dac_en[2:0];

	// ================================================================
	// Register writes and read data capture
	always_comb begin
		logic [7:0] wd;
		logic [7:0] st0;
		logic [7:0] st1;
		logic [7:0] rd;
		wd  = pwdata[7:0];
		st0 = {raw[0], 1'b0, filt[0], 5'h00};
		st1 = {raw[1], 1'b0, filt[1], 5'h00};
		rd  = 8'h00;
		next_r = r;
		if (wr) begin
			case (paddr[5:0])
				OFS_SWITCH:     next_r.sw         = wd & MSK_SWITCH;
				OFS_DAC_EN:     next_r.dac_en     = wd & MSK_DAC_EN;
				OFS_DAC0:       next_r.code0      = wd & MSK_CODE;
				OFS_DAC1:       next_r.code1      = wd & MSK_CODE;
				OFS_DAC2:       next_r.code2      = wd & MSK_CODE;
				OFS_CMP0_CTL:   next_r.ctl0       = wd & MSK_CMP_CTL;
				OFS_CMP0_TRIM:  next_r.trim0      = wd & MSK_CMP_TRM;
				OFS_CMP1_CTL:   next_r.ctl1       = wd & MSK_CMP_CTL;
				OFS_CMP1_TRIM:  next_r.trim1      = wd & MSK_CMP_TRM;
				OFS_CMP_SHARED: next_r.shared_cfg = wd & MSK_SHARED;
				OFS_OPA_CTL:    next_r.opa_ctl    = wd & MSK_OPA_CTL;
				OFS_OPA_TRIM:   next_r.opa_trim   = wd & MSK_OPA_TRM;
				default:        next_r.sw         = r.sw;
			endcase
		end
		// Read mux, sampled in setup so data stands through access
		case (paddr[5:0])
			OFS_SWITCH:     rd = r.sw;
			OFS_DAC_EN:     rd = r.dac_en;
			OFS_DAC0:       rd = r.code0;
			OFS_DAC1:       rd = r.code1;
			OFS_DAC2:       rd = r.code2;
			OFS_CMP0_CTL:   rd = (r.ctl0 & MSK_CMP_CTL) | st0;
			OFS_CMP0_TRIM:  rd = r.trim0;
			OFS_CMP1_CTL:   rd = (r.ctl1 & MSK_CMP_CTL) | st1;
			OFS_CMP1_TRIM:  rd = r.trim1;
			OFS_CMP_SHARED: rd = r.shared_cfg;
			OFS_OPA_CTL:    rd = r.opa_ctl | {2'h0, opamp_status && r.opa_trim[7], 5'h00};
			OFS_OPA_TRIM:   rd = r.opa_trim;
			default:        rd = 8'h00;
		endcase
		if (psel && !penable) begin
			next_r.prdata = (hit && !pwrite) ? {24'h0, rd} : 32'h0;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r            <= '0;
			r.sw         <= RST_SWITCH;
			r.trim0      <= RST_CMP_TRM;
			r.trim1      <= RST_CMP_TRM;
			r.opa_trim   <= RST_OPA_TRM;
		end else begin
			r <= next_r;
		end
	end

endmodule : pltc_top

// File: design/pltc_pkg.sv
// ================================================================
// Notes on behaviour
// - Receive switch: DAC2 at 0, pin at 1
// - Transmit pin: ground at 0, op-amp at 1
// - Three DAC enables; disabled output floats
// - Six-bit DAC codes from bits 5..0
// - Comparator output bit follows polarity inversion
// - Disabled comparator raw result forced low before polarity is applied
// - Debounced bit changes after N agreeing samples
// - Debounce field selects 0/32/64/127 periods
// - Unimplemented bits read as zero
// - Comparator 0 polarity at shared bit 4
// - Output select picks comparator 0 or 1
package pltc_pkg;

	// ================================================================
	// Register word offsets (byte addresses)
	localparam logic [5:0] OFS_SWITCH     = 6'h00; // switch_routing
	localparam logic [5:0] OFS_DAC_EN     = 6'h04; // dac_enable
	localparam logic [5:0] OFS_DAC0       = 6'h08; // dac0_code
	localparam logic [5:0] OFS_DAC1       = 6'h0c; // dac1_code
	localparam logic [5:0] OFS_DAC2       = 6'h10; // dac2_code
	localparam logic [5:0] OFS_CMP0_CTL   = 6'h14; // comparator0_control
	localparam logic [5:0] OFS_CMP0_TRIM  = 6'h18; // comparator0_offset_trim
	localparam logic [5:0] OFS_CMP1_CTL   = 6'h1c; // comparator1_control
	localparam logic [5:0] OFS_CMP1_TRIM  = 6'h20; // comparator1_offset_trim
	localparam logic [5:0] OFS_CMP_SHARED = 6'h24; // comparator_shared_config
	localparam logic [5:0] OFS_OPA_CTL    = 6'h28; // opamp_control
	localparam logic [5:0] OFS_OPA_TRIM   = 6'h2c; // opamp_offset_trim

	// ================================================================
	// Writable masks and reset values
	localparam logic [7:0] MSK_SWITCH  = 8'h07; // Three switch selects
	localparam logic [7:0] MSK_DAC_EN  = 8'h07; // Three DAC enables
	localparam logic [7:0] MSK_CODE    = 8'h3f; // Six-bit DAC code
	localparam logic [7:0] MSK_CMP_CTL = 8'h4f; // Enable, debounce, current
	localparam logic [7:0] MSK_CMP_TRM = 8'h7f; // Mode, ref, 5-bit trim
	localparam logic [7:0] MSK_SHARED  = 8'h7f; // Select, polarities, hysteresis
	localparam logic [7:0] MSK_OPA_CTL = 8'h41; // Enable, bandwidth
	localparam logic [7:0] MSK_OPA_TRM = 8'hff; // Mode, ref, 6-bit trim
	localparam logic [7:0] RST_SWITCH  = 8'h01; // Transmit to op-amp
	localparam logic [7:0] RST_CMP_TRM = 8'h10; // Mid trim
	localparam logic [7:0] RST_OPA_TRM = 8'h20; // Mid trim

	// ================================================================
	// Field positions
	localparam int BIT_TX_SEL    = 0; // Transmit pin select
	localparam int BIT_SENSE_SEL = 1; // Current / line voltage select
	localparam int BIT_RX_SEL    = 2; // Receive switch select
	localparam int BIT_CMP_RAW   = 7; // Comparator output bit
	localparam int BIT_CMP_EN    = 6; // Comparator enable
	localparam int BIT_CMP_FILT  = 5; // Debounced output
	localparam int BIT_DEB_LO    = 2; // Debounce field low bit
	localparam int BIT_POL0      = 4; // Comparator 0 polarity
	localparam int BIT_POL1      = 5; // Comparator 1 polarity
	localparam int BIT_OUT_SEL   = 6; // Output select
	localparam int DAC_W         = 6; // DAC code width

	// ================================================================
	// Debounce window lengths in system clock periods
	localparam logic [1:0] DEB_NONE = 2'h0; // No filtering
	localparam logic [6:0] DEB_LEN1 = 7'h1f; // 31..32 periods
	localparam logic [6:0] DEB_LEN2 = 7'h3f; // 63..64 periods
	localparam logic [6:0] DEB_LEN3 = 7'h7e; // 126..127 periods

	// Analog control carrier toward the front end
	typedef struct packed {
		logic             rx_switch_select;    // 1: receive pin, 0: DAC2
		logic             sense_switch_select; // 1: line voltage, 0: current sense
		logic             tx_pin_select;       // 1: op-amp output, 0: ground
		logic [2:0]       dac_enable;          // Per-DAC enable
		logic [DAC_W-1:0] dac0_code;           // DAC0 level
		logic [DAC_W-1:0] dac1_code;           // DAC1 level
		logic [DAC_W-1:0] dac2_code;           // DAC2 level
		logic [1:0]       cmp_enable;          // Comparator enables
		logic [3:0]       cmp_current;         // Current control, 2 bits each
		logic [13:0]      cmp_trim;            // Comparator trim, 7 bits each
		logic [3:0]       cmp_hysteresis;      // Hysteresis, 2 bits each
		logic             opamp_enable;        // Op-amp enable
		logic             opamp_bandwidth;     // Op-amp bandwidth
		logic [7:0]       opamp_trim;          // Op-amp trim
	} pltc_analog_s;

	// Debouncer state
	typedef struct packed {
		logic [6:0] run;   // Agreeing samples seen
		logic       last;  // Previous sample
		logic       held;  // Filtered value
	} pltc_deb_s;

	// Register file state
	typedef struct packed {
		logic [7:0] sw;
		logic [7:0] dac_en;
		logic [7:0] code0;
		logic [7:0] code1;
		logic [7:0] code2;
		logic [7:0] ctl0;
		logic [7:0] trim0;
		logic [7:0] ctl1;
		logic [7:0] trim1;
		logic [7:0] shared_cfg;
		logic [7:0] opa_ctl;
		logic [7:0] opa_trim;
		logic [31:0] prdata;
	} pltc_regs_s;

endpackage : pltc_pkg

// File: design/pltc_debounce.sv
`timescale 1ns/10ps
// Debounce filter for one comparator output bit
module pltc_debounce
	import pltc_pkg::*;
(
	input  wire logic       pclk,     // System clock
	input  wire logic       presetn,  // Asynchronous reset, active low
	input  wire logic [1:0] sel,      // Debounce time field
	input  wire logic       sample,   // Comparator output bit
	output logic            filtered  // Debounced bit
);

	pltc_deb_s st;      // Registered state
	pltc_deb_s next_st; // Next state
	logic [6:0] need;   // Window length for selected field

	// ================================================================
	// Window length decode
	always_comb begin
		case (sel)
			2'h1:    need = DEB_LEN1;
			2'h2:    need = DEB_LEN2;
			2'h3:    need = DEB_LEN3;
			default: need = 7'h00;
		endcase
	end

	// ================================================================
	// Count agreeing samples, adopt the value once the window is full
	always_comb begin
		next_st      = st;
		next_st.last = sample;
		if (sel == DEB_NONE) begin
			next_st.held = sample;
			next_st.run  = 7'h00;
		end else if (sample != st.last) begin
			next_st.run = 7'h00; // Disagreement restarts the window
		end else if (st.run < need) begin
			next_st.run = st.run + 7'h01;
		end else begin
			next_st.held = sample;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign filtered = st.held;

endmodule : pltc_debounce

// File: verif/pltc_checker.sv
`timescale 1ns/10ps
// ================================================================
// Register write, read and reset checks at the top ports
module pltc_checker
	import pltc_pkg::*;
(
	input wire logic         pclk,
	input wire logic         presetn,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [31:0]  paddr,
	input wire logic [31:0]  pwdata,
	input wire logic [31:0]  prdata,
	input wire logic [2:0]   dac_oe_n,
	input wire logic         cmp_out,
	input wire pltc_analog_s analog
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr; // Write access phase
	logic rd; // Read access phase
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	a_tx_select: assert property (wr && paddr == 32'(OFS_SWITCH)
		|=> analog.tx_pin_select == $past(pwdata[0]))
		else $error("tx select not loaded");
	a_rx_select: assert property (wr && paddr == 32'(OFS_SWITCH)
		|=> analog.rx_switch_select == $past(pwdata[2]))
		else $error("rx select not loaded");
	a_sense_select: assert property (wr && paddr == 32'(OFS_SWITCH) ##1 1
		|-> analog.sense_switch_select == $past(pwdata[1]))
		else $error("sense select not loaded");
	a_dac_drive: assert property (wr && paddr == 32'(OFS_DAC_EN)
		|=> dac_oe_n == ~$past(pwdata[2:0]))
		else $error("dac drive mismatch");
	a_code_load: assert property (wr && paddr == 32'(OFS_DAC0)
		|=> analog.dac0_code == $past(pwdata[5:0]))
		else $error("dac code not loaded");
	a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_switch_gaps: assert property (rd && paddr == 32'(OFS_SWITCH) |-> prdata[7:3] == 5'h0)
		else $error("switch gap bits set");
	a_ctl_gap: assert property (rd && paddr == 32'(OFS_CMP0_CTL) |-> !prdata[4])
		else $error("control gap bit set");
	a_reset_state: assert property ($rose(presetn)
		|-> analog.tx_pin_select && analog.dac_enable == 3'h0 && !cmp_out)
		else $error("reset state wrong");
	c_write: cover property (wr && paddr == 32'(OFS_DAC0));
	c_unmapped: cover property (rd && paddr == 32'h30);
	c_rise: cover property ($rose(cmp_out));
endmodule : pltc_checker

bind pltc_top pltc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .dac_oe_n(dac_oe_n),
	.cmp_out(cmp_out), .analog(analog));

// File: verif/pltc_afe_model.sv
`timescale 1ns/10ps
// ================================================================
// Analog front end: DAC references and two comparators
module pltc_afe_model
	import pltc_pkg::*;
(
	input wire logic [5:0]   line_level,   // Level on the sensed line
	input wire pltc_analog_s analog,       // Control word
	input wire logic [2:0]   dac_oe_n,     // DAC drive enables
	output logic             cmp0_above,   // Comparator 0 result
	output logic             cmp1_above,   // Comparator 1 result
	output logic             opamp_status  // Op-amp status
);
	logic [5:0] ref0; // Comparator 0 reference
	logic [5:0] ref1; // Comparator 1 reference
	// A floating DAC output leaks to ground at the comparator
	assign ref0 = dac_oe_n[0] ? 6'h00 : analog.dac0_code;
	assign ref1 = dac_oe_n[1] ? 6'h00 : analog.dac1_code;
	assign cmp0_above = line_level > ref0;
	assign cmp1_above = line_level > ref1;
	assign opamp_status = analog.opamp_enable;
endmodule : pltc_afe_model

// File: verif/testbench.sv
`timescale 1ns/10ps
// ================================================================
// Self-checking bench for the transceiver control bank
module testbench;
	import pltc_pkg::*;
	logic         pclk, presetn, psel, penable, pwrite, r;
	logic [31:0]  paddr, pwdata, prdata;
	logic         pready, pslverr, cmp0_above, cmp1_above, opamp_status, cmp_out;
	logic [2:0]   dac_oe_n;
	logic [5:0]   line_level;
	logic [7:0]   d;
	logic [7:0]   cd [3];
	pltc_analog_s analog;
	logic [32:0]  expq [$];
	int           mismatches, compares, i;
	logic [7:0]   rst [12] = '{8'h01, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h10, 8'h0, 8'h10, 8'h0, 8'h0, 8'h20};
	logic [7:0]   msk [12] = '{8'h07, 8'h07, 8'h3f, 8'h3f, 8'h3f, 8'h0f, 8'h7f, 8'h0f, 8'h7f, 8'h7f, 8'h41, 8'hff};
	int           dl [4] = '{0, 32, 64, 127};

	initial pclk = 1'b0;
	always #50 pclk = ~pclk;

	pltc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmp0_above(cmp0_above), .cmp1_above(cmp1_above), .opamp_status(opamp_status),
		.analog(analog), .dac_oe_n(dac_oe_n), .cmp_out(cmp_out));
	pltc_afe_model u_afe (.line_level(line_level), .analog(analog), .dac_oe_n(dac_oe_n),
		.cmp0_above(cmp0_above), .cmp1_above(cmp1_above), .opamp_status(opamp_status));

	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// APB transfer: setup, access until pready, then two idle cycles
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= {24'h0, v};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : xfer

	// Read with expected error flag and data noted first
	task automatic rd(input logic [7:0] a, input logic [7:0] ex);
		expq.push_back({(a > 8'h2c) || (a[1:0] != 2'h0), 24'h0, ex});
		xfer(1'b0, a, 8'h00);
	endtask : rd

	// Matches each completed read against the oldest note
	always @(posedge pclk)
		if (psel && penable && !pwrite && pready === 1'b1 && expq.size() > 0)
			chk({pslverr, prdata}, expq.pop_front());

	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// Watchdog well beyond the expected run
	initial begin
		#2000000;
		mismatches++;
		conclude();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, line_level} = '0;
		presetn = 1'b0;
		void'($urandom(28));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 12; i++)
			rd(8'(i * 4), rst[i]);
		$display("reset values done");
		for (i = 0; i < 12; i++) begin
			d = 8'($urandom) | 8'ha0;
			if (i == 5 || i == 7)
				d[6] = 1'b0;
			xfer(1'b1, 8'(i * 4), d);
			// Control fields that only reach the front end
			if (i == 9)
				chk(33'(analog.cmp_hysteresis), 33'(d[3:0]));
			if (i == 11)
				chk(33'(analog.opamp_trim), 33'(d));
			rd(8'(i * 4), d & msk[i]);
		end
		rd(8'h30, 8'h00);
		rd(8'h06, 8'h00);
		$display("register access done");
		for (i = 0; i < 8; i++) begin
			xfer(1'b1, 8'h00, 8'(i));
			chk(33'({analog.rx_switch_select, analog.sense_switch_select, analog.tx_pin_select}), 33'(i[2:0]));
			xfer(1'b1, 8'h04, 8'(i));
			chk(33'(dac_oe_n), 33'(i[2:0] ^ 3'h7));
		end
		for (i = 0; i < 3; i++) begin
			cd[i] = 8'($urandom);
			xfer(1'b1, 8'(8 + i * 4), cd[i]);
		end
		chk(33'({analog.dac2_code, analog.dac1_code, analog.dac0_code}),
			33'({cd[2][5:0], cd[1][5:0], cd[0][5:0]}));
		$display("routing and dac done");
		xfer(1'b1, 8'h04, 8'h07);
		xfer(1'b1, 8'h08, 8'h20);
		xfer(1'b1, 8'h0c, 8'h3f);
		line_level <= 6'h28;
		for (i = 0; i < 4; i++) begin
			r = i[1] ^ i[0];
			xfer(1'b1, 8'h24, {3'h0, i[0], 4'h0});
			xfer(1'b1, 8'h14, {1'b0, i[1], 6'h00});
			rd(8'h14, {r, i[1], r, 5'h00});
			chk(33'(cmp_out), 33'(r));
		end
		$display("comparator status done");
		xfer(1'b1, 8'h24, 8'h00);
		for (i = 1; i < 4; i++) begin
			line_level <= 6'h00;
			xfer(1'b1, 8'h14, {4'h4, i[1:0], 2'h3});
			repeat (140) @(posedge pclk);
			line_level <= 6'h28;
			repeat (dl[i] - 4) @(posedge pclk);
			chk(33'(cmp_out), 33'h0);
			repeat (8) @(posedge pclk);
			chk(33'(cmp_out), 33'h1);
		end
		xfer(1'b1, 8'h24, 8'h40);
		chk(33'(cmp_out), 33'h0);
		xfer(1'b1, 8'h24, 8'h00);
		chk(33'(cmp_out), 33'h1);
		$display("debounce and select done");
		conclude();
	end
endmodule : testbench
